// ===== shared/eic_pkg.sv
`default_nettype none
package eic_pkg;
  localparam logic [7:0] CTRL_RESET  = 8'hc0;
  localparam int         BIT_C_PRIO  = 7;
  localparam int         BIT_B_PRIO  = 6;
  localparam int         BIT_C_EN    = 4;
  localparam int         BIT_B_EN    = 3;
  localparam int         BIT_C_FLAG  = 1;
  localparam int         BIT_B_FLAG  = 0;
  localparam logic [7:0] CTRL_MASK   = 8'hdb;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STAT   = 4'h4;
  localparam logic [3:0] ADDR_MASK   = 4'h8;
  localparam logic [1:0] EVT_RESET   = 2'h0;
endpackage
`default_nettype wire

// ===== hdl/eic_edge.sv
`timescale 1ns/1ps
`default_nettype none
// synchronises a pin and pulses on its selected edge
module eic_edge (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  input  wire logic rising_i,
  output logic      event_o
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic [2:0] fill_r;
  logic [2:0] fill_nxt;

  always_comb begin
    sync_nxt = {sync_r[1:0], pin_i};
    fill_nxt = {fill_r[1:0], 1'b1};
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_r <= 3'h0;
      fill_r <= 3'h0;
    end else begin
      sync_r <= sync_nxt;
      fill_r <= fill_nxt;
    end
  end

  // only stages 1 and 2 are compared, stage 0 feeds stage 1 alone
  // held off until stage 2 has a real sample: a pin idling high would fake a rising edge
  assign event_o = fill_r[2] & (rising_i ? (sync_r[1] & ~sync_r[2]) : (~sync_r[1] & sync_r[2]));
endmodule
`default_nettype wire

// ===== hdl/eic_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// wraps the control byte with its flag logic and interrupt gating
module eic_ctrl (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic [1:0]  evt_i,
  input  wire logic        priority_mode_on_i,
  input  wire logic        global_high_enable_i,
  input  wire logic        global_low_enable_i,
  output logic [7:0]       ctrl_o,
  output logic             irq_high_o,
  output logic             irq_low_o
);
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [1:0] req;
  logic [1:0] prio;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_i) begin
      ctrl_nxt = wdata_i & eic_pkg::CTRL_MASK;
      // writing zero clears a flag, writing one leaves the flag as is
      ctrl_nxt[eic_pkg::BIT_B_FLAG] = ctrl_r[eic_pkg::BIT_B_FLAG] & wdata_i[eic_pkg::BIT_B_FLAG];
      ctrl_nxt[eic_pkg::BIT_C_FLAG] = ctrl_r[eic_pkg::BIT_C_FLAG] & wdata_i[eic_pkg::BIT_C_FLAG];
    end
    // set wins over a same-cycle clear; enables play no part
    if (evt_i[0]) begin
      ctrl_nxt[eic_pkg::BIT_B_FLAG] = 1'b1;
    end
    if (evt_i[1]) begin
      ctrl_nxt[eic_pkg::BIT_C_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= eic_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign req[0]  = ctrl_r[eic_pkg::BIT_B_FLAG] & ctrl_r[eic_pkg::BIT_B_EN];
  assign req[1]  = ctrl_r[eic_pkg::BIT_C_FLAG] & ctrl_r[eic_pkg::BIT_C_EN];
  assign prio[0] = ctrl_r[eic_pkg::BIT_B_PRIO];
  assign prio[1] = ctrl_r[eic_pkg::BIT_C_PRIO];

  // without priority mode all requests go high-vector under the global enable
  assign irq_high_o = global_high_enable_i &
                      (priority_mode_on_i ? |(req & prio) : |req);
  assign irq_low_o  = priority_mode_on_i & global_high_enable_i & global_low_enable_i &
                      |(req & ~prio);
  assign ctrl_o     = ctrl_r;
endmodule
`default_nettype wire

// ===== hdl/eic_top.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module eic_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // external inputs and edge selects
  input  wire logic        ext_in_b_i,
  input  wire logic        ext_in_c_i,
  input  wire logic        ext_in_b_rising_i,
  input  wire logic        ext_in_c_rising_i,
  // global controls from the core
  input  wire logic        priority_mode_on_i,
  input  wire logic        global_high_enable_i,
  input  wire logic        global_low_enable_i,
  // requests
  output logic             irq_high_o,
  output logic             irq_low_o,
  output logic             irq_o
);
  logic [1:0]  evt;
  logic [7:0]  ctrl;
  logic        wr_ctrl;
  logic        acc_r;
  logic        acc_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  stat_r;
  logic [1:0]  stat_nxt;
  logic [1:0]  mask_r;
  logic [1:0]  mask_nxt;
  logic        wr_go;
  logic        req;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      eic_edge u_edge (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .pin_i    (g == 0 ? ext_in_b_i : ext_in_c_i),
        .rising_i (g == 0 ? ext_in_b_rising_i : ext_in_c_rising_i),
        .event_o  (evt[g])
      );
    end
  endgenerate

  // one wait cycle per access: the answer comes on the second edge
  assign req   = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & acc_r & avs_byteenable_i[0];
  assign wr_ctrl = wr_go & (avs_address_i == eic_pkg::ADDR_CTRL);
  assign avs_waitrequest_o = req & ~acc_r;

  eic_ctrl u_ctrl (
    .clk_i                (clk_i),
    .srst_i               (srst_i),
    .wdata_i              (avs_writedata_i[7:0]),
    .wr_i                 (wr_ctrl),
    .evt_i                (evt),
    .priority_mode_on_i   (priority_mode_on_i),
    .global_high_enable_i (global_high_enable_i),
    .global_low_enable_i  (global_low_enable_i),
    .ctrl_o               (ctrl),
    .irq_high_o           (irq_high_o),
    .irq_low_o            (irq_low_o)
  );

  always_comb begin
    acc_nxt   = req & ~acc_r;
    rdata_nxt = 32'h0;
    stat_nxt  = stat_r | evt;
    mask_nxt  = mask_r;
    if (req & ~acc_r & avs_read_i) begin
      unique case (avs_address_i)
        eic_pkg::ADDR_CTRL: rdata_nxt = {24'h0, ctrl};
        eic_pkg::ADDR_STAT: rdata_nxt = {30'h0, stat_r};
        eic_pkg::ADDR_MASK: rdata_nxt = {30'h0, mask_r};
        default:            rdata_nxt = 32'h0;
      endcase
    end
    if (wr_go && avs_address_i == eic_pkg::ADDR_STAT) begin
      // write one to clear, a new event in the same cycle still sets
      stat_nxt = (stat_r & ~avs_writedata_i[1:0]) | evt;
    end
    if (wr_go && avs_address_i == eic_pkg::ADDR_MASK) begin
      mask_nxt = avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_r   <= 1'b0;
      rdata_r <= 32'h0;
      stat_r  <= eic_pkg::EVT_RESET;
      mask_r  <= eic_pkg::EVT_RESET;
    end else begin
      acc_r   <= acc_nxt;
      rdata_r <= rdata_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign irq_o          = |(stat_r & mask_r);
endmodule
`default_nettype wire

// ===== bench/eic_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eic_top_monitor (
  // bus side
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // interrupt side
  input wire logic        priority_mode_on_i,
  input wire logic        global_high_enable_i,
  input wire logic        irq_high_o,
  input wire logic        irq_low_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("late bus answer");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && !(avs_address_i inside {4'h0, 4'h4, 4'h8})
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  ctrl_unused_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h0
    |-> (avs_readdata_o & ~{24'h0, eic_pkg::CTRL_MASK}) == 32'h0) else $error("unused bit set");
  stat_width_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i != 4'h0
    |-> avs_readdata_o[31:2] == 30'h0) else $error("status read too wide");
  reset_quiet_a: assert property ($past(srst_i) |-> !irq_o && !irq_high_o && !irq_low_o)
    else $error("request after reset");
  all_off_a: assert property (priority_mode_on_i && !global_high_enable_i |-> !irq_high_o && !irq_low_o)
    else $error("request while disabled");
  high_gate_a: assert property (irq_high_o |-> global_high_enable_i)
    else $error("high request ungated");
  low_mode_a: assert property (irq_low_o |-> priority_mode_on_i)
    else $error("low request outside priority mode");
endmodule
bind eic_top eic_top_monitor i_mon (.*);
`default_nettype wire

// ===== bench/eic_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t bad %h", $time, a); end end
module eic_top_tb_top;
  logic        clk_i = '0, srst_i = '1, avs_read_i = '0, avs_write_i = '0, avs_waitrequest_o;
  logic        ext_in_b_i = '0, ext_in_c_i = '1, ext_in_b_rising_i = '1, ext_in_c_rising_i = '0;
  logic        priority_mode_on_i = '0, global_high_enable_i = '0, global_low_enable_i = '0;
  logic        irq_high_o, irq_low_o, irq_o;
  logic [3:0]  avs_address_i = '0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, q;
  int          n_errors = 0, n_tests = 0;
  always #12.5 clk_i = ~clk_i;
  eic_top i_dut (.*);
  task automatic finish_test;
    $display("%0d checks %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // answer taken at the rising edge that sees waitrequest low, request dropped right after it
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    q = avs_readdata_o;
    avs_write_i <= '0;
    avs_read_i <= '0;
    if (k >= 20) begin
      n_errors++;
      $display("[ERR] %0t bus timeout", $time);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus('0, a, 8'h00);
    `CHK(q, {24'h0, e})
  endtask
  task automatic hi(input logic e);
    @(negedge clk_i);
    `CHK(irq_high_o, e)
  endtask
  // b on its rising edge, c on its falling edge
  task automatic pulse;
    @(posedge clk_i);
    ext_in_b_i <= '1;
    ext_in_c_i <= '0;
    repeat (3) @(posedge clk_i);
    ext_in_b_i <= '0;
    ext_in_c_i <= '1;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic t_regs;
    rd(4'h0, 8'hc0);
    rd(4'h8, 8'h00);
    bus('1, 4'hc, 8'hff);
    rd(4'hc, 8'h00);
    // a write without lane 0 must leave the control byte alone
    avs_byteenable_i <= 4'he;
    bus('1, 4'h0, 8'h1b);
    avs_byteenable_i <= 4'hf;
    rd(4'h0, 8'hc0);
    $display("regs done");
  endtask
  task automatic t_poll;
    global_high_enable_i <= '1;
    pulse();
    hi('0);
    rd(4'h0, 8'hc3);
    rd(4'h4, 8'h03);
    bus('1, 4'h8, 8'h01);
    @(negedge clk_i);
    `CHK(irq_o, '1)
    bus('1, 4'h4, 8'h01);
    @(negedge clk_i);
    `CHK(irq_o, '0)
    bus('1, 4'h0, 8'hd2);
    hi('1);
    rd(4'h0, 8'hd2);
    bus('1, 4'h0, 8'hc0);
    hi('0);
    $display("poll done");
  endtask
  task automatic t_gate;
    bus('1, 4'h0, 8'hc8);
    pulse();
    hi('1);
    @(posedge clk_i);
    priority_mode_on_i <= '1;
    global_high_enable_i <= '0;
    hi('0);
    `CHK(irq_low_o, '0)
    @(posedge clk_i);
    global_high_enable_i <= '1;
    global_low_enable_i <= '1;
    bus('1, 4'h0, 8'h89);
    hi('0);
    `CHK(irq_low_o, '1)
    bus('1, 4'h0, 8'hc9);
    hi('1);
    $display("gate done");
  endtask
  // c set to rising edges while its pin idles high: a reset in mid-run must not fake an edge
  task automatic t_reset;
    @(posedge clk_i);
    srst_i <= '1;
    ext_in_c_rising_i <= '1;
    repeat (2) @(posedge clk_i);
    srst_i <= '0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(irq_o, '0)
    rd(4'h0, 8'hc0);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    $display("reset done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= '0;
    t_regs();
    t_poll();
    t_gate();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
